// file: eeprom_map.vh
// Constants for the two-wire EEPROM target: address layout, codes and timing.
`ifndef EEPROM_MAP_VH
`define EEPROM_MAP_VH

// ----------------------------------------------------------------------------
// Address word layout
// ----------------------------------------------------------------------------
// Device-type code in the upper four address bits.
`define DEV_TYPE_CODE 4'h0
`define DEV_TYPE_HI 7
`define DEV_TYPE_LO 4
`define DEV_STRAP_HI 3
`define DEV_STRAP_LO 1
`define DEV_RW_BIT 0

// ----------------------------------------------------------------------------
// Memory organisation
// ----------------------------------------------------------------------------
`define MEM_PAGES 32
`define MEM_PAGE_BYTES 8
`define MEM_WORDS 256
`define PAGE_OFS_BITS 3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
// Longest programming time in microseconds, and the clock rate in MHz.
`define PROG_TIME_US 5000
`define CLK_MHZ 200
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)

`endif

// file: eeprom_target.v
// Two-wire serial EEPROM target: bus engine, page write path, programming timer.
`timescale 1ns/1ps
`include "eeprom_map.vh"

module eeprom_target #(
    parameter PROG_CYCLES = `PROG_CYCLES,
    parameter [3:0] DEV_TYPE = `DEV_TYPE_CODE  // Value is arbitrary.
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    input wire clk_en,
    // Two-wire bus
    input wire scl,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // Straps and protection
    input wire [2:0] address_strap_inputs,
    input wire write_protect,
    // Status
    output reg busy_programming,
    output reg standby
);

    // ------------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_DEV = 3'd1;
    localparam [2:0] ST_WADDR = 3'd2;
    localparam [2:0] ST_WDATA = 3'd3;
    localparam [2:0] ST_RDATA = 3'd4;
    localparam [2:0] ST_RACK = 3'd5;

    localparam CNT_W = 32;

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------

    function [7:0] page_inc;
        input [7:0] a;
        begin
            page_inc = {a[7:`PAGE_OFS_BITS], a[`PAGE_OFS_BITS-1:0] + 3'd1};
        end
    endfunction

    // Address word check: type code and strap bits, direction bit ignored.
    function addr_hit;
        input [7:0] word;
        input [3:0] dev_type;
        input [2:0] straps;
        begin
            addr_hit = (word[`DEV_TYPE_HI:`DEV_TYPE_LO] == dev_type) &&
                       (word[`DEV_STRAP_HI:`DEV_STRAP_LO] == straps);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    reg [1:0] scl_s;
    reg [1:0] sda_s;
    reg [2:0] strap_s1;
    reg [2:0] strap_s2;
    reg wp_s1;
    reg wp_s2;
    reg scl_d;
    reg sda_d;

    // The bus idles high, so every line stage resets high; a low reset value
    // would show a false edge on the first enabled cycle.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s <= 2'b11;
            scl_d <= 1'b1;
        end else if (clk_en) begin
            scl_s <= {scl_s[0], scl};
            scl_d <= scl_s[1];
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_s <= 2'b11;
            sda_d <= 1'b1;
        end else if (clk_en) begin
            sda_s <= {sda_s[0], sda_in};
            sda_d <= sda_s[1];
        end
    end

    // Straps and protect are static levels but still cross in through two stages.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
            wp_s1 <= 1'b0;
            wp_s2 <= 1'b0;
        end else if (clk_en) begin
            strap_s1 <= address_strap_inputs;
            strap_s2 <= strap_s1;
            wp_s1 <= write_protect;
            wp_s2 <= wp_s1;
        end
    end

    // ------------------------------------------------------------------------
    // Frame events
    // ------------------------------------------------------------------------
    wire scl_q = scl_s[1];
    wire sda_q = sda_s[1];
    wire scl_rise = scl_q & ~scl_d;
    wire scl_fall = ~scl_q & scl_d;
    // Data edges with the clock steady high are frame events, not data.
    wire start_ev = scl_q & scl_d & sda_d & ~sda_q;
    wire stop_ev = scl_q & scl_d & ~sda_d & sda_q;

    // ------------------------------------------------------------------------
    // Memory and bus engine
    // ------------------------------------------------------------------------
    reg [7:0] mem [0:`MEM_WORDS-1];
    reg [7:0] page_buf [0:`MEM_PAGE_BYTES-1];
    reg [`MEM_PAGE_BYTES-1:0] page_vld_r;

    reg [2:0] state_r;
    reg [3:0] bit_r;
    reg [7:0] shift_r;
    reg [7:0] addr_r;
    reg [7:0] page_base_r;
    reg ack_phase_r;
    reg drive_low_r;
    reg wr_seen_r;
    reg rd_mode_r;
    reg [CNT_W-1:0] prog_cnt_r;
    reg prog_go_r;
    integer i;

    wire [7:0] rx_byte = {shift_r[6:0], sda_q};
    // The whole address word already sits in shift_r when the eighth bit ends.
    wire addr_match = addr_hit(shift_r, DEV_TYPE, strap_s2);
    wire prog_start = ~busy_programming & stop_ev & wr_seen_r & ~wp_s2;
    wire prog_done = busy_programming & (prog_cnt_r == {CNT_W{1'b0}});
    wire byte_done = scl_fall & ~ack_phase_r & (bit_r == 4'h8);
    wire buf_wr = ~busy_programming & byte_done & (state_r == ST_WDATA);

    // Open drain: only ever pull low, otherwise release.
    assign sda_out = 1'b0;
    assign sda_oe = drive_low_r;

    // ------------------------------------------------------------------------
    // Programming timer
    // ------------------------------------------------------------------------
    // Counts the self-timed cycle down from the configured length.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prog_cnt_r <= {CNT_W{1'b0}};
            prog_go_r <= 1'b0;
        end else if (clk_en) begin
            if (prog_start) begin
                prog_go_r <= 1'b1;
                prog_cnt_r <= PROG_CYCLES[CNT_W-1:0] - 1'b1;
            end else if (busy_programming) begin
                prog_go_r <= 1'b0;
                if (!prog_done) begin
                    prog_cnt_r <= prog_cnt_r - 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Array commit
    // ------------------------------------------------------------------------
    // The page buffer lands in the array on the first cycle of programming,
    // and only slots that received a byte are written.
    always @(posedge clk) begin
        if (clk_en && busy_programming && prog_go_r) begin
            for (i = 0; i < `MEM_PAGE_BYTES; i = i + 1) begin
                if (page_vld_r[i]) begin
                    mem[{page_base_r[7:`PAGE_OFS_BITS], i[2:0]}] <= page_buf[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Page buffer
    // ------------------------------------------------------------------------
    // Bytes of a page write collect here until the stop event.
    always @(posedge clk) begin
        if (clk_en && buf_wr) begin
            page_buf[addr_r[`PAGE_OFS_BITS-1:0]] <= shift_r;
        end
    end

    // ------------------------------------------------------------------------
    // Bus engine
    // ------------------------------------------------------------------------

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            addr_r <= 8'h00;
            page_base_r <= 8'h00;
            ack_phase_r <= 1'b0;
            drive_low_r <= 1'b0;
            wr_seen_r <= 1'b0;
            rd_mode_r <= 1'b0;
            page_vld_r <= {`MEM_PAGE_BYTES{1'b0}};
            busy_programming <= 1'b0;
            standby <= 1'b1;
        end else if (clk_en) begin
            if (busy_programming) begin
                // Bus is deaf during the self-timed cycle.
                drive_low_r <= 1'b0;
                state_r <= ST_IDLE;
                if (prog_go_r) begin
                    page_vld_r <= {`MEM_PAGE_BYTES{1'b0}};
                end
                if (prog_done) begin
                    busy_programming <= 1'b0;
                    standby <= 1'b1;
                end
            end else if (start_ev) begin
                state_r <= ST_DEV;
                bit_r <= 4'h0;
                ack_phase_r <= 1'b0;
                drive_low_r <= 1'b0;
                wr_seen_r <= 1'b0;
                page_vld_r <= {`MEM_PAGE_BYTES{1'b0}};
                standby <= 1'b0;
            end else if (stop_ev) begin
                drive_low_r <= 1'b0;
                state_r <= ST_IDLE;
                standby <= 1'b1;
                // Programming begins at stop after a written data byte unless protected.
                if (prog_start) begin
                    busy_programming <= 1'b1;
                    standby <= 1'b0;
                end
                wr_seen_r <= 1'b0;
            end else if (scl_rise && state_r != ST_IDLE) begin
                if (ack_phase_r) begin
                    // Controller's acknowledge after a read byte.
                    if (state_r == ST_RACK && sda_q) begin
                        state_r <= ST_IDLE;
                    end
                end else begin
                    shift_r <= rx_byte;
                    bit_r <= bit_r + 4'h1;
                end
            end else if (scl_fall && state_r != ST_IDLE) begin
                if (ack_phase_r) begin
                    ack_phase_r <= 1'b0;
                    drive_low_r <= 1'b0;
                    bit_r <= 4'h0;
                    if (state_r == ST_RDATA || state_r == ST_RACK) begin
                        state_r <= ST_RDATA;
                        drive_low_r <= ~mem[addr_r][7];
                        shift_r <= mem[addr_r];
                        addr_r <= addr_r + 8'h01;
                        bit_r <= 4'h0;
                    end
                end else if (state_r == ST_RDATA) begin
                    if (bit_r == 4'h8) begin
                        state_r <= ST_RACK;
                        ack_phase_r <= 1'b1;
                        drive_low_r <= 1'b0;
                    end else begin
                        // Each rising edge shifts the byte left, so bit 7 is
                        // always the next bit to put on the line.
                        drive_low_r <= ~shift_r[7];
                    end
                end else if (bit_r == 4'h8) begin
                    ack_phase_r <= 1'b1;
                    case (state_r)
                        ST_DEV: begin
                            if (addr_match) begin
                                drive_low_r <= 1'b1;
                                rd_mode_r <= shift_r[`DEV_RW_BIT];
                                state_r <= shift_r[`DEV_RW_BIT] ? ST_RDATA : ST_WADDR;
                            end else begin
                                state_r <= ST_IDLE;
                                standby <= 1'b1;
                            end
                        end
                        ST_WADDR: begin
                            drive_low_r <= 1'b1;
                            addr_r <= shift_r;
                            page_base_r <= shift_r;
                            state_r <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            drive_low_r <= 1'b1;
                            page_vld_r[addr_r[`PAGE_OFS_BITS-1:0]] <= 1'b1;
                            addr_r <= page_inc(addr_r);
                            wr_seen_r <= 1'b1;
                        end
                        default: begin
                            state_r <= ST_IDLE;
                        end
                    endcase
                end
            end
        end
    end

endmodule // eeprom_target

// file: eeprom_target_asserts.sv
// Port assertions for the two-wire EEPROM target.
`timescale 1ns/1ps
module eeprom_target_asserts #(
    parameter PROG_CYCLES = 1000
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Bus
    input wire scl,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire write_protect,
    // Status
    input wire busy_programming,
    input wire standby
);
    reg [31:0] prog_cnt_r;
    // Counts the cycles of the current programming pulse.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            prog_cnt_r <= 32'h0000_0000;
        else
            prog_cnt_r <= busy_programming ? prog_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_prog_end; $fell(busy_programming); endsequence
    property p_open_drain; sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line driven high");
    property p_oe_scl_low; $changed(sda_oe) |-> !scl; endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data change with clock high");
    property p_oe_hold; $rose(sda_oe) |-> sda_oe [*8]; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("low bit too short");
    property p_busy_standby; busy_programming |-> !standby; endproperty
    a_busy_standby: assert property (p_busy_standby) else $error("standby while busy");
    property p_oe_busy; busy_programming |-> !sda_oe; endproperty
    a_oe_busy: assert property (p_oe_busy) else $error("bus answered while busy");
    property p_prog_start; $rose(busy_programming) |-> scl && sda_in && !write_protect; endproperty
    a_prog_start: assert property (p_prog_start) else $error("bad programming start");
    property p_prog_len; s_prog_end |-> prog_cnt_r >= PROG_CYCLES - 2 && prog_cnt_r <= PROG_CYCLES + 2; endproperty
    a_prog_len: assert property (p_prog_len) else $error("programming length wrong");
    property p_end_standby; s_prog_end |-> standby; endproperty
    a_end_standby: assert property (p_end_standby) else $error("no standby after programming");
endmodule // eeprom_target_asserts

// file: bus_ctl_model.sv
// Two-wire bus controller model for the EEPROM target bench.
`timescale 1ns/1ps
module bus_ctl_model (
    // Clock and wire level
    input wire clk,
    input wire sda,
    // Lines driven, high on the data line means released
    output reg scl = 1'b1,
    output reg sda_rel = 1'b1
);
    reg r;
    integer i;
    task drive(input c, input d);
        scl = c;
        sda_rel = d;
        repeat (4) @(negedge clk);
    endtask
    task bit_io(input b, output o);
        drive(1'b0, b);
        drive(1'b1, b);
        o = sda;
        drive(1'b1, b);
        drive(1'b0, b);
    endtask
    task start;
        drive(1'b0, 1'b1);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
        drive(1'b0, 1'b0);
    endtask
    task stop;
        drive(1'b0, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
    endtask
    task recover;
        for (i = 0; i < 9 && sda !== 1'b1; i++)
            bit_io(1'b1, r);
    endtask
    task wbyte(input [7:0] d, output ack);
        for (i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task rbyte(input more, output [7:0] d);
        for (i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(!more, r);
    endtask
endmodule // bus_ctl_model

// file: two_wire_eeprom_slave_write_path_test.sv
// Self-checking bench for the two-wire EEPROM target write path.
`timescale 1ns/1ps
module two_wire_eeprom_slave_write_path_test;
    localparam PROG_CYCLES = 400;
    localparam [3:0] DEV_TYPE = 4'h3; // Value is arbitrary.
    localparam [2:0] STRAP = 3'h5;
    localparam [7:0] ADDR_W = {DEV_TYPE, STRAP, 1'b0};
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg write_protect = 1'b0;
    reg ack;
    reg [7:0] rd;
    reg [7:0] exp_q [0:8];
    integer miscompares = 0, checks = 0, cyc = 0, k;
    wire scl, sda_rel, sda_out, sda_oe, busy_programming, standby;
    wire sda = sda_rel & (sda_oe ? sda_out : 1'b1);
    always #2.5 clk = ~clk;
    eeprom_target #(.PROG_CYCLES(PROG_CYCLES), .DEV_TYPE(DEV_TYPE)) i_dut (
        .clk(clk), .reset_n(reset_n), .clk_en(1'b1), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_inputs(STRAP),
        .write_protect(write_protect), .busy_programming(busy_programming), .standby(standby));
    bus_ctl_model i_ctl (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
    task tally_and_finish;
        $display("miscompares %0d checks %0d", miscompares, checks);
        if (miscompares == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] wa, input [7:0] d0, input integer n);
        i_ctl.start;
        i_ctl.wbyte(ADDR_W, ack);
        chk(ack, 1);
        i_ctl.wbyte(wa, ack);
        chk(ack, 1);
        for (k = 0; k < n; k++) begin
            i_ctl.wbyte(d0 + k[7:0], ack);
            chk(ack, 1);
        end
        i_ctl.stop;
    endtask
    task wait_prog;
        for (k = 0; k < 600 && busy_programming !== 1'b0; k++)
            @(negedge clk);
        chk(busy_programming, 0);
        chk(standby, 1);
    endtask
    task rdseq(input [7:0] wa, input integer n);
        i_ctl.start;
        i_ctl.wbyte(ADDR_W, ack);
        chk(ack, 1);
        i_ctl.wbyte(wa, ack);
        chk(ack, 1);
        i_ctl.start;
        i_ctl.wbyte(ADDR_W | 8'h01, ack);
        chk(ack, 1);
        for (k = 0; k < n; k++) begin
            i_ctl.rbyte(k < n - 1, rd);
            chk(rd, exp_q[k]);
        end
        i_ctl.stop;
    endtask
    task t_mismatch;
        i_ctl.start;
        i_ctl.wbyte(ADDR_W ^ 8'h04, ack);
        chk(ack, 0);
        i_ctl.stop;
        chk(standby, 1);
    endtask
    task t_byte_write;
        wr(8'h00, 8'ha5, 1);
        chk(busy_programming, 1);
        i_ctl.start;
        i_ctl.wbyte(ADDR_W, ack);
        chk(ack, 0);
        i_ctl.stop;
        wait_prog;
        exp_q[0] = 8'ha5;
        rdseq(8'h00, 1);
    endtask
    // Ten bytes from the next-to-last slot of the top page wrap inside it.
    task t_page_wrap;
        wr(8'hfe, 8'h40, 10);
        wait_prog;
        for (k = 0; k < 8; k++)
            exp_q[k] = 8'h42 + k[7:0];
        exp_q[8] = 8'ha5;
        rdseq(8'hf8, 9);
    endtask
    task t_protect;
        write_protect = 1'b1;
        wr(8'h00, 8'h3c, 1);
        chk(busy_programming, 0);
        exp_q[0] = 8'ha5;
        rdseq(8'h00, 1);
        write_protect = 1'b0;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        i_ctl.recover;
        t_mismatch;
        t_byte_write;
        t_page_wrap;
        t_protect;
        tally_and_finish;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish;
        end
    end
endmodule // two_wire_eeprom_slave_write_path_test
bind eeprom_target eeprom_target_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
    .clk(clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_protect(write_protect),
    .busy_programming(busy_programming), .standby(standby));
